// ==== src/clcr_defines.svh ====
// offsets, field positions, reset values and limits of the camera link register bank
// assumes 16-bit host words; watchdog limits count link clock cycles
// Notes on behaviour
// [R1] bank selected when address bit 20 low and bit 12 high; bits 11..0 pick
// [R2] host uses full 16-bit word accesses only, never single bytes
// [R3] host leaves these registers alone while power save is on
// [R4] timeout select 00/01/10/11 gives 1023/64/128/64 link cycles, 00 after reset
// [R5] local control bits 13..12 read zero, writes ignored
// [R6] local control bits 11..8 read a fixed revision code, writes ignored
// [R7] bit 7 mirrors cable sense: 0 cable present, 1 absent; read only
// [R8] local control bits 6 and 4 read zero, writes ignored
// [R9] bit 5 mirrors remote power sense: 1 powered; read only
// [R10] software reads cable status 1 as no cable, whatever power status shows
// [R11] bit 3 turns the internal link clock on; off after reset
// [R12] bit 2 drives the cable clock output; off after reset
// [R13] bit 1 switches remote power on; off after reset
// [R14] bit 0 set disables the watchdog; watchdog active after reset
// [R15] local control reads show status fields that writes cannot set
// [R16] reserved extension word ignores writes and reads zero
// [R17] command word holds a 13-bit index in 15..3 and operation in 2..0
// [R18] dirty set on command write, power loss, cable removal; cleared per operation
// [R19] timeout flag bit 14 set on watchdog expiry or unpowered remote; cleared on command write
// [R20] all 16 command bits go out; readback shows dirty and timeout in 15..14
// [R21] operation codes: reset, stream end, write reg, read reg, streams, two no-ops
`ifndef CLCR_DEFINES_SVH
`define CLCR_DEFINES_SVH

`define CLCR_OFF_LCTRL   13'h1000
`define CLCR_OFF_LRSVD   13'h1002
`define CLCR_OFF_CMDW    13'h1004
`define CLCR_OFF_DATA_LO 13'h1008

`define CLCR_ADDR_BANK   12
`define CLCR_ADDR_HIGH   20

`define CLCR_TOSEL_HI    15
`define CLCR_TOSEL_LO    14
`define CLCR_REV_HI      11
`define CLCR_REV_LO      8
`define CLCR_BIT_CABLE   7
`define CLCR_BIT_RPWR    5
`define CLCR_BIT_LCLK    3
`define CLCR_BIT_CCLK    2
`define CLCR_BIT_PWR     1
`define CLCR_BIT_WDDIS   0
`define CLCR_BIT_DIRTY   15
`define CLCR_BIT_TOUT    14
`define CLCR_IDX_HI      13

`define CLCR_LIMIT_00    10'h3ff
`define CLCR_LIMIT_01    10'h040
`define CLCR_LIMIT_10    10'h080
`define CLCR_LIMIT_11    10'h040
`define CLCR_COUNT_MAX   10'h3ff

`define CLCR_TOSEL_RST   2'h0
`define CLCR_RSVD_READ   16'h0000
`define CLCR_CMDW_RST    16'h0000

`endif

// ==== src/clcr_pkg.sv ====
// types shared by the camera link register bank
// assumes the constants header supplies all numeric positions
package clcr_pkg;

  typedef struct packed {
    logic        csN;
    logic        memSelN;
    logic        rdN;
    logic        wrN;
    logic [20:0] addr;
    logic [15:0] wdata;
  } clcr_host_bus_t;

  typedef struct packed {
    logic [1:0] timeoutSel;
    logic       linkClkOn;
    logic       cableClkOn;
    logic       remotePwrOn;
    logic       wdDisable;
  } clcr_lctrl_t;

  typedef enum logic [2:0] {
    OP_REMOTE_RESET = 3'h0,
    OP_STREAM_END   = 3'h1,
    OP_WRITE_REG    = 3'h2,
    OP_READ_REG     = 3'h3,
    OP_WRITE_STREAM = 3'h4,
    OP_NOP_A        = 3'h5,
    OP_NOP_B        = 3'h6,
    OP_READ_STREAM  = 3'h7
  } clcr_op_t;

  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_BUSY = 1'b1
  } clcr_link_state_t;

endpackage

// ==== src/clcr_sync.sv ====
// two-stage level synchroniser, any width, reset value chosen per instance
// assumes each bit is an independent level or toggle
`timescale 1ns/10ps

module clcr_sync #(
  parameter int unsigned   W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ==== src/clcr_regs.sv ====
// camera link register bank: local control, reserved extension and command word
// host pins arrive unsynchronised; link side runs on clk_link, stopped when unused
`timescale 1ns/10ps
`include "clcr_defines.svh"

module clcr_regs #(
  parameter logic [3:0] REV_CODE = 4'h5  // arbitrary revision value
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     clk_link,
  input  wire clcr_pkg::clcr_host_bus_t hostBus,
  output logic      [15:0]              hostDataOut,
  output logic                          hostDataOe,
  output logic                          hostAck,
  input  wire logic                     cableSensePin,
  input  wire logic                     remotePowerSensePin,
  input  wire logic                     remoteAck,
  output logic                          internalLinkClockOn,
  output logic                          cableClockOut,
  output logic                          remotePowerOn,
  output logic                          linkCommandValid,
  output logic      [15:0]              linkCommand
);

  function automatic logic [9:0] timeoutLimit(input logic [1:0] sel);
    unique case (sel)
      2'b00: timeoutLimit = `CLCR_LIMIT_00;
      2'b01: timeoutLimit = `CLCR_LIMIT_01;
      2'b10: timeoutLimit = `CLCR_LIMIT_10;
      2'b11: timeoutLimit = `CLCR_LIMIT_11;
    endcase
  endfunction

  clcr_pkg::clcr_host_bus_t busS;
  logic [1:0]               pinS;
  logic [1:0]               evtS;
  logic                     cableS;
  logic                     pwrS;
  logic                     sel;
  logic [12:0]              off;
  logic                     rdStart;
  logic                     wrStart;
  logic                     rdPrev_q;
  logic                     wrPrev_q;
  logic                     cmdWr;
  logic                     dataWr;
  logic                     dataRd;
  logic                     ackEvt;
  logic                     toutEvt;
  logic [1:0]               evtPrev_q;
  logic                     cablePrev_q;
  logic                     pwrPrev_q;
  logic                     powerLoss;
  logic                     cableGone;
  logic                     dirtyClr;
  clcr_pkg::clcr_op_t       op;
  clcr_pkg::clcr_lctrl_t    lctrl_q;
  logic [15:0]              commandWord_q;
  logic                     cmdTgl_q;
  logic                     dirty_q;
  logic                     timeout_q;
  logic [15:0]              readWord;
  logic [15:0]              hostDataOut_q;
  logic                     hostDataOe_q;
  logic                     hostAck_q;
  logic                     cableClockOut_q;

  // host pins: all fields pass two stages; strobes idle high
  clcr_sync #(
    .W    ($bits(clcr_pkg::clcr_host_bus_t)),
    .INIT ('1)
  ) uBusSync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   (hostBus),
    .dout  (busS)
  );

  // sense pins: reset as no cable, remote unpowered
  clcr_sync #(
    .W    (2),
    .INIT (2'b10)
  ) uPinSync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   ({cableSensePin, remotePowerSensePin}),
    .dout  (pinS)
  );

  assign cableS = pinS[1];
  assign pwrS   = pinS[0];

  // [R1] register window decode
  assign sel = !busS.csN && !busS.memSelN && !busS.addr[`CLCR_ADDR_HIGH]
               && busS.addr[`CLCR_ADDR_BANK];
  // word address only: the host never issues byte cycles here
  assign off     = {busS.addr[12:1], 1'b0};
  assign rdStart = sel && !busS.rdN && rdPrev_q;
  assign wrStart = sel && !busS.wrN && wrPrev_q;
  assign cmdWr   = wrStart && (off == `CLCR_OFF_CMDW);
  assign dataWr  = wrStart && (off >= `CLCR_OFF_DATA_LO);
  assign dataRd  = rdStart && (off >= `CLCR_OFF_DATA_LO);
  assign op      = clcr_pkg::clcr_op_t'(commandWord_q[2:0]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= busS.rdN;
      wrPrev_q <= busS.wrN;
    end
  end

  // [R15] write side holds only select and control bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lctrl_q.timeoutSel  <= `CLCR_TOSEL_RST;
      lctrl_q.linkClkOn   <= 1'b0;
      lctrl_q.cableClkOn  <= 1'b0;
      lctrl_q.remotePwrOn <= 1'b0;
      lctrl_q.wdDisable   <= 1'b0;
    end else if (wrStart && (off == `CLCR_OFF_LCTRL)) begin
      lctrl_q.timeoutSel  <= busS.wdata[`CLCR_TOSEL_HI:`CLCR_TOSEL_LO];
      lctrl_q.linkClkOn   <= busS.wdata[`CLCR_BIT_LCLK];
      lctrl_q.cableClkOn  <= busS.wdata[`CLCR_BIT_CCLK];
      lctrl_q.remotePwrOn <= busS.wdata[`CLCR_BIT_PWR];
      lctrl_q.wdDisable   <= busS.wdata[`CLCR_BIT_WDDIS];
    end
  end

  // [R17] command word capture, toggle tells the link side
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      commandWord_q <= `CLCR_CMDW_RST;
      cmdTgl_q      <= 1'b0;
    end else if (cmdWr) begin
      commandWord_q <= busS.wdata;
      cmdTgl_q      <= !cmdTgl_q;
    end
  end

  // [R11] [R12] [R13] control bits drive pins
  assign internalLinkClockOn = lctrl_q.linkClkOn;
  assign remotePowerOn       = lctrl_q.remotePwrOn;

  // cable clock at half clk_sys; parked low when off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cableClockOut_q <= 1'b0;
    end else begin
      cableClockOut_q <= lctrl_q.cableClkOn && !cableClockOut_q;
    end
  end
  assign cableClockOut = cableClockOut_q;

  // events returned from the link domain as toggles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evtPrev_q   <= 2'b00;
      cablePrev_q <= 1'b1;
      pwrPrev_q   <= 1'b0;
    end else begin
      evtPrev_q   <= evtS;
      cablePrev_q <= cableS;
      pwrPrev_q   <= pwrS;
    end
  end

  assign ackEvt    = evtS[1] ^ evtPrev_q[1];
  assign toutEvt   = evtS[0] ^ evtPrev_q[0];
  assign powerLoss = pwrPrev_q && !pwrS;
  assign cableGone = !cablePrev_q && cableS;

  // [R18] per-operation clear conditions
  assign dirtyClr = (ackEvt && (op == clcr_pkg::OP_REMOTE_RESET
                                || op == clcr_pkg::OP_STREAM_END))
                    || (dataWr && op == clcr_pkg::OP_WRITE_REG)
                    || (dataRd && op == clcr_pkg::OP_READ_REG);

  // [R18] dirty flag; a set in the clear cycle wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirty_q <= 1'b0;
    end else if (cmdWr || powerLoss || cableGone) begin
      dirty_q <= 1'b1;
    end else if (dirtyClr) begin
      dirty_q <= 1'b0;
    end
  end

  // [R19] timeout flag; expiry or no power beats the write clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_q <= 1'b0;
    end else if (toutEvt || !pwrS) begin
      timeout_q <= 1'b1;
    end else if (cmdWr) begin
      timeout_q <= 1'b0;
    end
  end

  // [R5] [R6] [R7] [R8] [R9] [R16] [R20] readback layout
  always_comb begin
    readWord = `CLCR_RSVD_READ;
    if (off == `CLCR_OFF_LCTRL) begin
      readWord[`CLCR_TOSEL_HI:`CLCR_TOSEL_LO] = lctrl_q.timeoutSel;
      readWord[`CLCR_REV_HI:`CLCR_REV_LO]     = REV_CODE;
      readWord[`CLCR_BIT_CABLE]               = cableS;
      readWord[`CLCR_BIT_RPWR]                = pwrS;
      readWord[`CLCR_BIT_LCLK]                = lctrl_q.linkClkOn;
      readWord[`CLCR_BIT_CCLK]                = lctrl_q.cableClkOn;
      readWord[`CLCR_BIT_PWR]                 = lctrl_q.remotePwrOn;
      readWord[`CLCR_BIT_WDDIS]               = lctrl_q.wdDisable;
    end else if (off == `CLCR_OFF_CMDW) begin
      readWord[`CLCR_IDX_HI:0]   = commandWord_q[`CLCR_IDX_HI:0];
      readWord[`CLCR_BIT_DIRTY]  = dirty_q;
      readWord[`CLCR_BIT_TOUT]   = timeout_q;
    end
  end

  // data port range reads back zero here; its payload lives elsewhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut_q <= 16'h0000;
      hostDataOe_q  <= 1'b0;
      hostAck_q     <= 1'b0;
    end else begin
      if (rdStart) begin
        hostDataOut_q <= readWord;
      end
      hostDataOe_q <= sel && !busS.rdN;
      hostAck_q    <= rdStart || wrStart;
    end
  end

  assign hostDataOut = hostDataOut_q;
  assign hostDataOe  = hostDataOe_q;
  assign hostAck     = hostAck_q;

  // link clock domain
  logic [1:0]                   linkRst_q;
  logic                         linkRstN;
  logic [4:0]                   cfgL;
  logic                         ackL;
  logic                         cmdTglL;
  logic [1:0]                   toSelL;
  logic                         wdDisL;
  logic                         cmdSeenL_q;
  logic                         ackPrevL_q;
  logic                         newCmdL;
  logic                         ackRiseL;
  logic                         wdExpire;
  clcr_pkg::clcr_link_state_t   linkState_q;
  logic [9:0]                   wdCount_q;
  logic [15:0]                  linkCommand_q;
  logic                         ackTgl_q;
  logic                         toutTgl_q;

  // reset asserts at once, releases on the link clock
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      linkRst_q <= 2'b00;
    end else begin
      linkRst_q <= {linkRst_q[0], 1'b1};
    end
  end
  assign linkRstN = linkRst_q[1];

  // quasi-static settings, the command toggle and the ack pin
  clcr_sync #(
    .W    (5),
    .INIT (5'h00)
  ) uLinkSync (
    .clk   (clk_link),
    .rst_n (linkRstN),
    .din   ({remoteAck, cmdTgl_q, lctrl_q.timeoutSel, lctrl_q.wdDisable}),
    .dout  (cfgL)
  );

  assign ackL     = cfgL[4];
  assign cmdTglL  = cfgL[3];
  assign toSelL   = cfgL[2:1];
  assign wdDisL   = cfgL[0];
  assign newCmdL  = cmdTglL ^ cmdSeenL_q;
  assign ackRiseL = ackL && !ackPrevL_q;

  // [R4] [R14] expiry once the count reaches the selected limit
  assign wdExpire = (linkState_q == clcr_pkg::LINK_BUSY) && !wdDisL
                    && (wdCount_q == timeoutLimit(toSelL));

  always_ff @(posedge clk_link or negedge linkRstN) begin
    if (!linkRstN) begin
      cmdSeenL_q <= 1'b0;
      ackPrevL_q <= 1'b0;
    end else begin
      cmdSeenL_q <= cmdTglL;
      ackPrevL_q <= ackL;
    end
  end

  // a new command restarts the cycle even if one is pending
  always_ff @(posedge clk_link or negedge linkRstN) begin
    if (!linkRstN) begin
      linkState_q <= clcr_pkg::LINK_IDLE;
      wdCount_q   <= 10'h000;
    end else if (newCmdL) begin
      linkState_q <= clcr_pkg::LINK_BUSY;
      wdCount_q   <= 10'h000;
    end else begin
      unique case (linkState_q)
        clcr_pkg::LINK_IDLE: begin
          wdCount_q <= 10'h000;
        end
        clcr_pkg::LINK_BUSY: begin
          if (ackRiseL || wdExpire) begin
            linkState_q <= clcr_pkg::LINK_IDLE;
          end else if (wdCount_q != `CLCR_COUNT_MAX) begin
            wdCount_q <= wdCount_q + 10'h001;
          end
        end
      endcase
    end
  end

  // [R20] [R21] whole written word goes out, every code included
  // word was settled two link edges before its toggle arrives
  always_ff @(posedge clk_link or negedge linkRstN) begin
    if (!linkRstN) begin
      linkCommand_q <= `CLCR_CMDW_RST;
    end else if (newCmdL) begin
      linkCommand_q <= commandWord_q;
    end
  end

  assign linkCommand      = linkCommand_q;
  assign linkCommandValid = linkState_q;

  // completion events travel back as toggles
  always_ff @(posedge clk_link or negedge linkRstN) begin
    if (!linkRstN) begin
      ackTgl_q  <= 1'b0;
      toutTgl_q <= 1'b0;
    end else if (!newCmdL && linkState_q == clcr_pkg::LINK_BUSY) begin
      if (ackRiseL) begin
        ackTgl_q <= !ackTgl_q;
      end else if (wdExpire) begin
        toutTgl_q <= !toutTgl_q;
      end
    end
  end

  clcr_sync #(
    .W    (2),
    .INIT (2'b00)
  ) uEvtSync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   ({ackTgl_q, toutTgl_q}),
    .dout  (evtS)
  );

  property p_decode;
    @(posedge clk_sys) disable iff (!rst_n)
      hostAck_q |-> $past(sel) && $past(busS.addr[12]) && !$past(busS.addr[20]);
  endproperty
  a_decode: assert property (p_decode) // [R1]
    else $error("access answered outside the register window");

  property p_lctrl_fixed;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdStart && off == `CLCR_OFF_LCTRL) |=>
        hostDataOut_q[13:12] == 2'b00 && hostDataOut_q[11:8] == REV_CODE;
  endproperty
  a_lctrl_fixed: assert property (p_lctrl_fixed) // [R5] [R6]
    else $error("fixed local control bits read wrong");

  property p_lctrl_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdStart && off == `CLCR_OFF_LCTRL) |=> !hostDataOut_q[6] && !hostDataOut_q[4];
  endproperty
  a_lctrl_zero: assert property (p_lctrl_zero) // [R8]
    else $error("bits 6 or 4 read non-zero");

  property p_sense_mirror;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdStart && off == `CLCR_OFF_LCTRL) |=>
        hostDataOut_q[7] == $past(cableS) && hostDataOut_q[5] == $past(pwrS);
  endproperty
  a_sense_mirror: assert property (p_sense_mirror) // [R7] [R9]
    else $error("sense status bits do not follow the pins");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrStart && off == `CLCR_OFF_LCTRL) |=> ##1
        internalLinkClockOn == $past(busS.wdata[3], 2)
        && remotePowerOn == $past(busS.wdata[1], 2);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // [R11] [R13]
    else $error("control bits did not follow the write");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdStart && off == `CLCR_OFF_LRSVD) |=> hostDataOut_q == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [R16]
    else $error("reserved extension read non-zero");

  property p_dirty_set;
    @(posedge clk_sys) disable iff (!rst_n)
      cmdWr |=> dirty_q && commandWord_q == $past(busS.wdata);
  endproperty
  a_dirty_set: assert property (p_dirty_set) // [R17] [R18]
    else $error("command write did not store word and set dirty");

  property p_tout_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmdWr && pwrS && !toutEvt) |=> !timeout_q;
  endproperty
  a_tout_clear: assert property (p_tout_clear) // [R19]
    else $error("timeout flag not cleared by command write");

  property p_cmd_readback;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdStart && off == `CLCR_OFF_CMDW) |=>
        hostDataOut_q[15:14] == {$past(dirty_q), $past(timeout_q)};
  endproperty
  a_cmd_readback: assert property (p_cmd_readback) // [R20]
    else $error("command readback does not show dirty and timeout");

  property p_wd_expire;
    @(posedge clk_link) disable iff (!linkRstN)
      (wdExpire && !newCmdL && !ackRiseL) |=>
        toutTgl_q != $past(toutTgl_q) && linkState_q == clcr_pkg::LINK_IDLE;
  endproperty
  a_wd_expire: assert property (p_wd_expire) // [R4]
    else $error("watchdog expiry not reported");

  property p_wd_off;
    @(posedge clk_link) disable iff (!linkRstN)
      wdDisL |=> $stable(toutTgl_q);
  endproperty
  a_wd_off: assert property (p_wd_off) // [R14]
    else $error("watchdog fired while disabled");

endmodule

// ==== bench/clcr_remote_model.sv ====
// remote camera module seen from the far end of the cable link
// assumes the bench sets cable presence and stalling; link clock comes from the bench
`timescale 1ns/10ps

module clcr_remote_model #(
  parameter int ACK_DLY = 20
) (
  input  wire logic clk_link,
  input  wire logic rst_n,
  input  wire logic linkCommandValid,
  input  wire logic remotePowerOn,
  input  wire logic cableAbsent,
  input  wire logic stall,
  output logic      remoteAck,
  output logic      remotePowerSensePin,
  output logic      cableSensePin
);
  int waitCnt;

  assign cableSensePin       = cableAbsent;
  assign remotePowerSensePin = remotePowerOn & ~cableAbsent;

  // ack held as a level; stalling lets the watchdog run out
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt   <= 0;
      remoteAck <= 1'b0;
    end else if (!linkCommandValid) begin
      waitCnt   <= 0;
      remoteAck <= 1'b0;
    end else begin
      waitCnt   <= waitCnt + 1;
      remoteAck <= (waitCnt >= ACK_DLY) && !stall && remotePowerSensePin;
    end
  end
endmodule

// ==== bench/camera_link_control_regs_test.sv ====
// self-checking bench for the camera link register bank
// assumes the remote model on the link side; host pins change at falling clock edges
`timescale 1ns/10ps

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module camera_link_control_regs_test;
  localparam logic [3:0] REV = 4'ha;  // arbitrary revision value

  logic                     clk_sys     = 1'b0;
  logic                     clk_link    = 1'b0;
  logic                     rst_n       = 1'b0;
  logic                     cableAbsent = 1'b0;
  logic                     stall       = 1'b0;
  clcr_pkg::clcr_host_bus_t hb          = '{1'b1, 1'b1, 1'b1, 1'b1, 21'h0, 16'h0};
  logic [15:0]              hostDataOut, linkCommand, rdq, w;
  logic                     hostDataOe, hostAck, cableSensePin, remotePowerSensePin;
  logic                     remoteAck, internalLinkClockOn, cableClockOut, remotePowerOn;
  logic                     linkCommandValid, ackd, c0;
  int                       failures    = 0;
  int                       comparisons = 0;
  int                       n;

  always #10 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #15 clk_link = ~clk_link;
  end

  clcr_regs #(.REV_CODE(REV)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .hostBus(hb), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostAck(hostAck),
    .cableSensePin(cableSensePin), .remotePowerSensePin(remotePowerSensePin),
    .remoteAck(remoteAck), .internalLinkClockOn(internalLinkClockOn),
    .cableClockOut(cableClockOut), .remotePowerOn(remotePowerOn),
    .linkCommandValid(linkCommandValid), .linkCommand(linkCommand));

  clcr_remote_model u_remote (.clk_link(clk_link), .rst_n(rst_n),
    .linkCommandValid(linkCommandValid), .remotePowerOn(remotePowerOn),
    .cableAbsent(cableAbsent), .stall(stall), .remoteAck(remoteAck),
    .remotePowerSensePin(remotePowerSensePin), .cableSensePin(cableSensePin));

  function automatic logic [15:0] expLctrl(logic [15:0] v, logic cab);
    return {v[15:14], 2'b00, REV, cab, 1'b0, v[1] & ~cab, 1'b0, v[3:0]};
  endfunction

  function automatic int wdLimit(logic [1:0] ts);
    return (ts == 2'b00) ? 1023 : (ts == 2'b10) ? 128 : 64;
  endfunction

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // whole words, one strobe at a time
  task automatic acc(input logic wr, input logic [20:0] a, input logic [15:0] d,
                     input logic ms = 1'b0);
    @(negedge clk_sys);
    hb   = '{1'b0, ms, wr, ~wr, a, d};
    ackd = 1'b0;
    for (int i = 0; i < 8 && !ackd; i++) begin
      @(negedge clk_sys);
      if (hostAck === 1'b1) begin
        ackd = 1'b1;
        rdq  = hostDataOut;
        if (!wr) `CHK(hostDataOe, 1'b1)
      end
    end
    hb = '{1'b1, 1'b1, 1'b1, 1'b1, a, d};
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic waitLink(input logic lvl);
    for (int i = 0; i < 2000 && linkCommandValid !== lvl; i++) @(negedge clk_link);
    `CHK(linkCommandValid, lvl)
  endtask

  initial begin
    n = $urandom(19614);
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    acc(1'b0, 21'h001000, 16'h0);
    `CHK({ackd, rdq}, {1'b1, expLctrl(16'h0, 1'b0)})
    `CHK({internalLinkClockOn, cableClockOut, remotePowerOn}, 3'b000)
    for (int k = 0; k < 10; k++) begin
      w = (k == 0) ? 16'hffff : 16'($urandom);
      cableAbsent = 1'($urandom);
      acc(1'b1, 21'h001000, w);
      acc(1'b0, 21'h001000, 16'h0);
      `CHK({ackd, rdq}, {1'b1, expLctrl(w, cableAbsent)})
      `CHK({internalLinkClockOn, remotePowerOn}, {w[3], w[1]})
      c0 = cableClockOut;
      @(negedge clk_sys);
      `CHK(cableClockOut, w[2] & ~c0)
    end
    cableAbsent = 1'b0;
    acc(1'b1, 21'h001000, 16'h000a);
    acc(1'b1, 21'h001002, 16'hffff);
    acc(1'b0, 21'h001002, 16'h0);
    `CHK({ackd, rdq}, 17'h10000)
    acc(1'b1, 21'h101000, 16'h4005);
    `CHK(ackd, 1'b0)
    acc(1'b0, 21'h001000, 16'h0, 1'b1);
    `CHK(ackd, 1'b0)
    acc(1'b0, 21'h001000, 16'h0);
    `CHK(rdq, expLctrl(16'h000a, 1'b0))
    // every operation code, the last four (3 down to 0) clear dirty
    for (int op = 7; op >= 0; op--) begin
      w = {13'($urandom), op[2:0]};
      acc(1'b1, 21'h001004, w);
      acc(1'b0, 21'h001004, 16'h0);
      `CHK(rdq, {2'b10, w[13:0]})
      waitLink(1'b1);
      `CHK(linkCommand, w)
      waitLink(1'b0);
      if (op == 2) acc(1'b1, 21'h001008, 16'h1234);
      if (op == 3) acc(1'b0, 21'h001ffe, 16'h0);
      repeat (4) @(negedge clk_sys);
      acc(1'b0, 21'h001004, 16'h0);
      `CHK(rdq, {op > 3, 1'b0, w[13:0]})
    end
    stall = 1'b1;
    for (int ts = 0; ts < 4; ts++) begin
      acc(1'b1, 21'h001000, {ts[1:0], 14'h000a});
      acc(1'b1, 21'h001004, 16'h0005);
      waitLink(1'b1);
      n = 0;
      while (linkCommandValid === 1'b1 && n < 1100) begin
        @(negedge clk_link);
        n++;
      end
      `CHK(n inside {[wdLimit(ts[1:0]) : wdLimit(ts[1:0]) + 2]}, 1'b1)
      acc(1'b0, 21'h001004, 16'h0);
      `CHK(rdq[15:14], 2'b11)
    end
    acc(1'b1, 21'h001000, 16'h400b);
    acc(1'b1, 21'h001004, 16'h0001);
    waitLink(1'b1);
    repeat (300) @(negedge clk_link);
    `CHK(linkCommandValid, 1'b1)
    stall = 1'b0;
    waitLink(1'b0);
    repeat (4) @(negedge clk_sys);
    acc(1'b0, 21'h001004, 16'h0);
    `CHK(rdq[15:14], 2'b00)
    acc(1'b1, 21'h001000, 16'h0008);
    acc(1'b0, 21'h001004, 16'h0);
    `CHK(rdq[15:14], 2'b11)
    test_done();
  end

  initial begin
    #300us;
    failures++;
    test_done();
  end
endmodule
